// ### design/sslrx_regs.svh
// Purpose: constants for the link receive and transmit dispatch block
// Assumes: one dword per mclk_in cycle, 100 MHz
// Notes:   frame limits, done reason codes and the align period live here as macros; kind codes sit in sslrx_pkg
`ifndef SSLRX_REGS_SVH
`define SSLRX_REGS_SVH

// ----------------------------------------
// frame limits
// ----------------------------------------
`define SSLRX_MAX_FRAME_BYTES   1024
`define SSLRX_BYTES_PER_DWORD   4
`define SSLRX_LEN_W             12
`define SSLRX_CREDIT_W          8
`define SSLRX_FIFO_DEPTH        16

// ----------------------------------------
// done reason codes
// ----------------------------------------
`define SSLRX_DONE_NORMAL       2'h0
`define SSLRX_DONE_CREDIT_TO    2'h1
`define SSLRX_DONE_ACK_TO       2'h2

// ----------------------------------------
// align insertion
// ----------------------------------------
`define SSLRX_ALIGN_PERIOD      8'hff

`endif

// ### design/sslrx_pkg.sv
// Purpose: types shared by the dispatch block and its bench
// Assumes: the link carries one dword plus a kind code per cycle
// Notes:   kind codes stand in for encoded primitives
package sslrx_pkg;

	typedef enum logic [3:0] {
		SSLRX_K_IDLE,
		SSLRX_K_ALIGN,
		SSLRX_K_RRDY,
		SSLRX_K_ACK,
		SSLRX_K_NAK,
		SSLRX_K_DONE,
		SSLRX_K_SOF,
		SSLRX_K_DATA,
		SSLRX_K_EOF,
		SSLRX_K_BREAK
	} sslrx_kind_e;

	typedef struct packed {
		sslrx_kind_e kind;
		logic [1:0]  reason;
		logic [31:0] data;
	} sslrx_dword_s;

	// end-of-frame facts supplied alongside the eof dword
	typedef struct packed {
		logic crc_ok;
		logic addr_ok;
	} sslrx_eof_info_s;

	typedef struct packed {
		logic crc_err;
		logic balanced;
	} sslrx_verdict_s;

endpackage

// ### design/sslrx_fifo.sv
// Purpose: small synchronous fifo with valid/ready on both sides
// Assumes: single clock, synchronous active-high reset
// Notes:   full and empty come from an occupancy count
`timescale 1ns/1ps
module sslrx_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16
) (
	input  wire logic             mclk_in,
	input  wire logic             rst_in,
	input  wire logic [WIDTH-1:0] wr_data_in,
	input  wire logic             wr_valid_in,
	output logic                  wr_ready_out,
	output logic [WIDTH-1:0]      rd_data_out,
	output logic                  rd_valid_out,
	input  wire logic             rd_ready_in
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic             push;
	logic             pop;

	assign wr_ready_out = (count != (AW+1)'(DEPTH));
	assign rd_valid_out = (count != '0);
	assign push         = wr_valid_in && wr_ready_out;
	assign pop          = rd_valid_out && rd_ready_in;
	assign rd_data_out  = mem[rd_ptr];

	always_ff @(posedge mclk_in) begin
		if (push) begin
			mem[wr_ptr] <= wr_data_in;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// ### design/sslrx_dispatch.sv
// Purpose: receive dispatch, frame check, verdict, credit and ack balance, transmit dispatch
// Assumes: rx dwords already decoded into kinds; eof carries crc and address facts
// Notes:   transmit frame control and timeouts sit outside; frame payload leaves via fifo
// Operation
// - each received credit primitive pulses a credit-received event
// - each received ack or nak is reported, kind kept, and counted by the ack balance monitor only
// - received done passes its reason to close logic and an event to checker
// - done with ack-timeout reason raises remote ack timeout notice
// - done with credit-timeout reason raises remote credit timeout notice
// - sof goes to checker; eof goes to close logic and checker
// - discard and flag illegal: no credit, too long, bad address with good crc, or after done
// - second sof without eof: flag protocol violation, restart byte count and credit, keep buffering dwords
// - accept only with credit, length within limit, and matching addresses or a crc error
// - crc error travels with the frame into the verdict stage
// - good frame: request ack, tell credit tracker, report received with balance
// - crc-bad frame: request nak, tell credit tracker, report failed frame
// - verdict returns to idle one cycle after entry, on the edge that registers its outputs
// - no credit at connection start; grant only when buffers free up
// - outstanding grant requests never exceed free frame buffers
// - count grants sent and acks issued; credit extended while grants lead
// - count acks/naks sent against received and report balance
// - balance counters equalised when a connection starts
// - transmit requested credit, ack, nak, done or framed payload
// - with nothing pending send idle, with align inserted periodically
// - requested dword goes out in the next free slot
// - priority align, credit, ack or nak, done
// - sof just before first payload dword, eof just after last
// - pending primitives may interleave with frame dwords
// - all machines except the align counter run from enable and stop on close, break request or break; the align counter runs from reset
`timescale 1ns/1ps
`include "sslrx_regs.svh"
module sslrx_dispatch #(
	parameter int FIFO_W     = 32,
	parameter int FIFO_DEPTH = `SSLRX_FIFO_DEPTH,
	parameter int CREDIT_W   = `SSLRX_CREDIT_W
) (
	input  wire logic                      mclk_in,
	input  wire logic                      rst_in,
	input  wire logic                      ssp_enable_in,
	input  wire logic                      ssp_stop_in,
	input  wire sslrx_pkg::sslrx_dword_s   rx_dword_in,
	input  wire sslrx_pkg::sslrx_eof_info_s rx_eof_info_in,
	input  wire logic                      buf_free_in,
	output logic                           credit_rcvd_out,
	output logic                           ack_rcvd_out,
	output logic                           nak_rcvd_out,
	output logic                           done_rcvd_out,
	output logic [1:0]                     done_reason_out,
	output logic                           eof_rcvd_out,
	output logic                           remote_ack_to_out,
	output logic                           remote_credit_to_out,
	output logic                           illegal_frame_out,
	output logic                           protocol_violation_out,
	output logic                           frame_rcvd_out,
	output logic                           frame_balanced_out,
	output logic                           frame_failed_out,
	output logic                           credit_extended_out,
	output logic                           ack_balanced_out,
	output logic                           stopped_out,
	output logic [FIFO_W-1:0]              rx_data_out,
	output logic                           rx_valid_out,
	input  wire logic                      rx_ready_in,
	input  wire logic                      tx_done_req_in,
	input  wire logic [1:0]                tx_done_reason_in,
	output logic                           tx_done_ack_out,
	input  wire logic [31:0]               tx_frame_data_in,
	input  wire logic                      tx_frame_valid_in,
	input  wire logic                      tx_frame_last_in,
	output logic                           tx_frame_ready_out,
	output sslrx_pkg::sslrx_dword_s        tx_dword_out
);
	// ----------------------------------------
	// run control
	// ----------------------------------------
	logic run;
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			run <= 1'b0;
		end else if (ssp_stop_in || rx_dword_in.kind == sslrx_pkg::SSLRX_K_BREAK) begin
			run <= 1'b0;
		end else if (ssp_enable_in) begin
			run <= 1'b1;
		end
	end
	assign stopped_out = !run;
	logic start;
	assign start = ssp_enable_in && !run;

	function automatic logic is_kind(input sslrx_pkg::sslrx_dword_s d, input sslrx_pkg::sslrx_kind_e k);
		is_kind = (d.kind == k);
	endfunction

	// ----------------------------------------
	// receive dispatcher
	// ----------------------------------------
	logic rx_sof;
	logic rx_eof;
	logic rx_data;
	assign rx_sof  = run && is_kind(rx_dword_in, sslrx_pkg::SSLRX_K_SOF);
	assign rx_eof  = run && is_kind(rx_dword_in, sslrx_pkg::SSLRX_K_EOF);
	assign rx_data = run && is_kind(rx_dword_in, sslrx_pkg::SSLRX_K_DATA);

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			credit_rcvd_out      <= 1'b0;
			ack_rcvd_out         <= 1'b0;
			nak_rcvd_out         <= 1'b0;
			done_rcvd_out        <= 1'b0;
			done_reason_out      <= 2'h0;
			eof_rcvd_out         <= 1'b0;
			remote_ack_to_out    <= 1'b0;
			remote_credit_to_out <= 1'b0;
		end else begin
			credit_rcvd_out      <= run && is_kind(rx_dword_in, sslrx_pkg::SSLRX_K_RRDY);
			ack_rcvd_out         <= run && is_kind(rx_dword_in, sslrx_pkg::SSLRX_K_ACK);
			nak_rcvd_out         <= run && is_kind(rx_dword_in, sslrx_pkg::SSLRX_K_NAK);
			done_rcvd_out        <= run && is_kind(rx_dword_in, sslrx_pkg::SSLRX_K_DONE);
			if (run && is_kind(rx_dword_in, sslrx_pkg::SSLRX_K_DONE)) begin
				done_reason_out <= rx_dword_in.reason;
			end
			eof_rcvd_out         <= rx_eof;
			remote_ack_to_out    <= run && is_kind(rx_dword_in, sslrx_pkg::SSLRX_K_DONE)
				&& rx_dword_in.reason == `SSLRX_DONE_ACK_TO;
			remote_credit_to_out <= run && is_kind(rx_dword_in, sslrx_pkg::SSLRX_K_DONE)
				&& rx_dword_in.reason == `SSLRX_DONE_CREDIT_TO;
		end
	end

	// ----------------------------------------
	// frame checker
	// ----------------------------------------
	typedef enum logic [1:0] {SSLRX_CHK_IDLE, SSLRX_CHK_IN_FRAME, SSLRX_CHK_VERDICT} sslrx_chk_e;
	sslrx_chk_e              chk_state;
	logic [`SSLRX_LEN_W-1:0] frame_bytes;
	logic                    done_seen;
	logic                    frame_credit;
	logic                    fifo_ready;
	logic                    fifo_push;
	sslrx_pkg::sslrx_verdict_s verdict;
	logic                    accept;
	logic                    len_ok;

	assign len_ok = frame_bytes <= `SSLRX_LEN_W'(`SSLRX_MAX_FRAME_BYTES);
	assign accept = frame_credit && len_ok && (rx_eof_info_in.addr_ok || !rx_eof_info_in.crc_ok)
		&& !done_seen;
	assign fifo_push = (chk_state == SSLRX_CHK_IN_FRAME) && rx_data && len_ok;

	always_ff @(posedge mclk_in) begin
		if (rst_in || start) begin
			done_seen <= 1'b0;
		end else if (run && is_kind(rx_dword_in, sslrx_pkg::SSLRX_K_DONE)) begin
			done_seen <= 1'b1;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			chk_state              <= SSLRX_CHK_IDLE;
			frame_bytes            <= '0;
			frame_credit           <= 1'b0;
			verdict                <= '0;
			illegal_frame_out      <= 1'b0;
			protocol_violation_out <= 1'b0;
		end else begin
			illegal_frame_out      <= 1'b0;
			protocol_violation_out <= 1'b0;
			case (chk_state)
				SSLRX_CHK_IDLE: begin
					if (rx_sof) begin
						chk_state    <= SSLRX_CHK_IN_FRAME;
						frame_bytes  <= '0;
						frame_credit <= credit_extended_out;
					end
				end
				SSLRX_CHK_IN_FRAME: begin
					if (!run) begin
						chk_state <= SSLRX_CHK_IDLE;
					end else if (rx_sof) begin
						protocol_violation_out <= 1'b1;
						frame_bytes            <= '0;
						frame_credit           <= credit_extended_out;
					end else if (rx_data && frame_bytes <= `SSLRX_LEN_W'(`SSLRX_MAX_FRAME_BYTES)) begin
						frame_bytes <= frame_bytes + `SSLRX_LEN_W'(`SSLRX_BYTES_PER_DWORD);
					end else if (rx_eof) begin
						if (accept) begin
							chk_state       <= SSLRX_CHK_VERDICT;
							verdict.crc_err <= !rx_eof_info_in.crc_ok;
						end else begin
							chk_state         <= SSLRX_CHK_IDLE;
							illegal_frame_out <= 1'b1;
						end
					end
				end
				SSLRX_CHK_VERDICT: begin
					chk_state <= SSLRX_CHK_IDLE;
				end
				default: chk_state <= SSLRX_CHK_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// verdict stage
	// ----------------------------------------
	logic ack_req;
	logic nak_req;
	logic ack_issued;
	assign ack_issued = (chk_state == SSLRX_CHK_VERDICT);

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			frame_rcvd_out     <= 1'b0;
			frame_failed_out   <= 1'b0;
			frame_balanced_out <= 1'b0;
		end else begin
			frame_rcvd_out   <= ack_issued && !verdict.crc_err;
			frame_failed_out <= ack_issued && verdict.crc_err;
			if (ack_issued) begin
				frame_balanced_out <= ack_balanced_out;
			end
		end
	end

	// ----------------------------------------
	// inbound credit tracker and grant scheduler
	// ----------------------------------------
	logic [CREDIT_W-1:0] rrdy_sent;
	logic [CREDIT_W-1:0] acks_issued;
	logic [CREDIT_W-1:0] free_bufs;
	logic                rrdy_go;
	assign credit_extended_out = (rrdy_sent != acks_issued);

	always_ff @(posedge mclk_in) begin
		if (rst_in || start) begin
			free_bufs <= '0;
		end else begin
			free_bufs <= free_bufs + CREDIT_W'(buf_free_in) - CREDIT_W'(rrdy_go);
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in || start) begin
			rrdy_sent   <= '0;
			acks_issued <= '0;
		end else begin
			rrdy_sent   <= rrdy_sent + CREDIT_W'(rrdy_go);
			acks_issued <= acks_issued + CREDIT_W'(ack_issued);
		end
	end

	// ----------------------------------------
	// inbound ack balance monitor
	// ----------------------------------------
	logic [CREDIT_W-1:0] an_sent;
	logic [CREDIT_W-1:0] an_rcvd;
	logic                an_go;
	assign ack_balanced_out = (an_sent == an_rcvd);

	always_ff @(posedge mclk_in) begin
		if (rst_in || start) begin
			an_sent <= '0;
			an_rcvd <= '0;
		end else begin
			an_sent <= an_sent + CREDIT_W'(an_go);
			an_rcvd <= an_rcvd + CREDIT_W'(ack_rcvd_out || nak_rcvd_out);
		end
	end

	// ----------------------------------------
	// transmit dispatcher
	// ----------------------------------------
	logic [7:0] align_cnt;
	logic       align_due;
	logic       in_tx_frame;
	logic       frame_go;
	logic       done_go;
	logic       ack_pend;
	logic       nak_pend;
	logic       eof_due;
	assign align_due = (align_cnt == `SSLRX_ALIGN_PERIOD);
	// priority chain; frame dwords fill whatever slot primitives leave
	assign rrdy_go  = run && !align_due && (free_bufs != '0);
	assign an_go    = run && !align_due && !rrdy_go && (ack_pend || nak_pend);
	assign done_go  = run && !align_due && !rrdy_go && !an_go && !eof_due && tx_done_req_in && !in_tx_frame;
	assign frame_go = run && !align_due && !rrdy_go && !an_go && !eof_due && !done_go && tx_frame_valid_in;
	assign tx_done_ack_out    = done_go;
	assign tx_frame_ready_out = frame_go && in_tx_frame;

	always_ff @(posedge mclk_in) begin
		if (rst_in || start) begin
			ack_pend <= 1'b0;
			nak_pend <= 1'b0;
		end else begin
			ack_pend <= (ack_pend && !(an_go && ack_pend)) || (ack_issued && !verdict.crc_err);
			nak_pend <= (nak_pend && !(an_go && !ack_pend)) || (ack_issued && verdict.crc_err);
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			align_cnt <= 8'h00;
		end else begin
			align_cnt <= align_due ? 8'h00 : align_cnt + 8'h01;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in || start) begin
			in_tx_frame <= 1'b0;
		end else if (frame_go) begin
			in_tx_frame <= !(in_tx_frame && tx_frame_last_in) && (in_tx_frame || 1'b1);
		end else if (frame_go == 1'b0 && in_tx_frame && !tx_frame_valid_in) begin
			in_tx_frame <= in_tx_frame;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in || start) begin
			eof_due <= 1'b0;
		end else if (tx_frame_ready_out && tx_frame_last_in) begin
			eof_due <= 1'b1;
		end else if (run && !align_due && !rrdy_go && !an_go) begin
			eof_due <= 1'b0;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			tx_dword_out <= '0;
		end else begin
			tx_dword_out <= '0;
			if (!run) begin
				tx_dword_out.kind <= sslrx_pkg::SSLRX_K_IDLE;
			end else if (align_due) begin
				tx_dword_out.kind <= sslrx_pkg::SSLRX_K_ALIGN;
			end else if (rrdy_go) begin
				tx_dword_out.kind <= sslrx_pkg::SSLRX_K_RRDY;
			end else if (an_go) begin
				tx_dword_out.kind <= ack_pend ? sslrx_pkg::SSLRX_K_ACK : sslrx_pkg::SSLRX_K_NAK;
			end else if (eof_due) begin
				tx_dword_out.kind <= sslrx_pkg::SSLRX_K_EOF;
			end else if (done_go) begin
				tx_dword_out.kind   <= sslrx_pkg::SSLRX_K_DONE;
				tx_dword_out.reason <= tx_done_reason_in;
			end else if (frame_go && !in_tx_frame) begin
				tx_dword_out.kind <= sslrx_pkg::SSLRX_K_SOF;
			end else if (frame_go) begin
				tx_dword_out.kind <= sslrx_pkg::SSLRX_K_DATA;
				tx_dword_out.data <= tx_frame_data_in;
			end else begin
				tx_dword_out.kind <= sslrx_pkg::SSLRX_K_IDLE;
			end
		end
	end

	// ----------------------------------------
	// receive payload buffer
	// ----------------------------------------
	logic unused_ready;
	assign unused_ready = fifo_ready;
	sslrx_fifo #(
		.WIDTH (FIFO_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.mclk_in      (mclk_in),
		.rst_in       (rst_in),
		.wr_data_in   (FIFO_W'(rx_dword_in.data)),
		.wr_valid_in  (fifo_push),
		.wr_ready_out (fifo_ready),
		.rd_data_out  (rx_data_out),
		.rd_valid_out (rx_valid_out),
		.rd_ready_in  (rx_ready_in)
	);

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_rrdy_event;
		@(posedge mclk_in) disable iff (rst_in)
		(run && rx_dword_in.kind == sslrx_pkg::SSLRX_K_RRDY) |=> credit_rcvd_out;
	endproperty
	a_rrdy_event: assert property (p_rrdy_event) else $error("credit event missing");

	property p_remote_ack_to;
		@(posedge mclk_in) disable iff (rst_in)
		remote_ack_to_out |-> done_rcvd_out && done_reason_out == `SSLRX_DONE_ACK_TO;
	endproperty
	a_remote_ack_to: assert property (p_remote_ack_to) else $error("ack timeout notice wrong");

	property p_verdict_one;
		@(posedge mclk_in) disable iff (rst_in)
		ack_issued |=> (frame_rcvd_out ^ frame_failed_out) && chk_state == SSLRX_CHK_IDLE;
	endproperty
	a_verdict_one: assert property (p_verdict_one) else $error("verdict report wrong");

	property p_credit_flag;
		@(posedge mclk_in) disable iff (rst_in)
		$rose(credit_extended_out) |-> $past(rrdy_go);
	endproperty
	a_credit_flag: assert property (p_credit_flag) else $error("credit rose without grant");

	property p_no_free_no_grant;
		@(posedge mclk_in) disable iff (rst_in)
		(free_bufs == '0) |-> !rrdy_go;
	endproperty
	a_no_free_no_grant: assert property (p_no_free_no_grant) else $error("grant without buffer");

	property p_start_balanced;
		@(posedge mclk_in) disable iff (rst_in)
		start |=> ack_balanced_out && !credit_extended_out;
	endproperty
	a_start_balanced: assert property (p_start_balanced) else $error("counters not reset");

	property p_align_first;
		@(posedge mclk_in) disable iff (rst_in)
		(run && align_due && !ssp_stop_in) |=> tx_dword_out.kind == sslrx_pkg::SSLRX_K_ALIGN;
	endproperty
	a_align_first: assert property (p_align_first) else $error("align not first");

	property p_illegal_len;
		@(posedge mclk_in) disable iff (rst_in)
		(chk_state == SSLRX_CHK_IN_FRAME && rx_eof && !len_ok) |=> illegal_frame_out;
	endproperty
	a_illegal_len: assert property (p_illegal_len) else $error("long frame kept");
endmodule

// ### testbench/sslrx_peer.sv
// Purpose: remote port model feeding decoded dwords to the dispatch block
// Assumes: one dword per mclk_in cycle, driven at the falling edge
// Notes:   sends frames only on credit it has seen granted, unless told to force one
`timescale 1ns/1ps
module sslrx_peer (
	input  wire logic                    mclk_in,
	input  wire sslrx_pkg::sslrx_dword_s tx_dword_in,
	output sslrx_pkg::sslrx_dword_s      rx_dword_out,
	output sslrx_pkg::sslrx_eof_info_s   rx_eof_info_out
);
	int credit = 0;
	initial begin
		rx_dword_out = '0;
		rx_eof_info_out = '0;
	end
	always @(posedge mclk_in) begin
		if (tx_dword_in.kind === sslrx_pkg::SSLRX_K_RRDY) begin
			credit++;
		end
	end
	task automatic put(input sslrx_pkg::sslrx_kind_e k, input logic [1:0] r, input logic [31:0] d,
		input logic [1:0] e);
		@(negedge mclk_in);
		rx_dword_out = '{k, r, d};
		rx_eof_info_out = e;
	endtask
	// stale data and eof facts are inverted so they never pass for fresh ones
	task automatic idle();
		@(negedge mclk_in);
		rx_dword_out = '{sslrx_pkg::SSLRX_K_IDLE, 2'h0, ~rx_dword_out.data};
		rx_eof_info_out = ~rx_eof_info_out;
	endtask
	task automatic frame(input int n, input logic [1:0] e, input bit force_it);
		if (credit == 0 && !force_it) begin
			return;
		end
		credit -= !force_it;
		put(sslrx_pkg::SSLRX_K_SOF, 2'h0, 32'h0, 2'h0);
		for (int i = 0; i < n; i++) begin
			put(sslrx_pkg::SSLRX_K_DATA, 2'h0, 32'h00001000 + i, 2'h0);
		end
		put(sslrx_pkg::SSLRX_K_EOF, 2'h0, 32'h0, e);
		idle();
	endtask
endmodule

// ### testbench/sslrx_dispatch_tb_top.sv
// Purpose: self-checking bench for the dispatch block and its link peer
// Assumes: inputs change at the falling edge
// Notes:   event pulses are counted at each rising edge and judged as totals
`timescale 1ns/1ps
module sslrx_dispatch_tb_top;
	localparam int CR = 0, AK = 1, NK = 2, DN = 3, EF = 4, RAT = 5, RCT = 6, IL = 7, PV = 8, FR = 9, FF = 10;
	logic                       mclk_in = 1'b0;
	logic                       rst_in = 1'b1;
	logic                       enable = 1'b0;
	logic                       stop = 1'b0;
	logic                       buf_free = 1'b0;
	logic                       rx_ready = 1'b1;
	logic                       done_req = 1'b0;
	logic [1:0]                 done_rsn = 2'h0;
	logic [31:0]                f_data = 32'h0;
	logic                       f_valid = 1'b0;
	logic                       f_last = 1'b0;
	sslrx_pkg::sslrx_dword_s    rx_dword, tx_dword;
	sslrx_pkg::sslrx_eof_info_s eof_info;
	logic [10:0]                evt;
	logic [1:0]                 done_reason;
	logic                       cred_ext, ack_bal, stopped, rx_valid, done_ack, f_ready, fr_bal;
	logic [31:0]                rx_data;
	int                         ev[11];
	int                         txk[16];
	sslrx_pkg::sslrx_dword_s    seq[$];
	int                         miscompares = 0;
	int                         n_checks = 0;
	sslrx_dispatch i_sslrx_dispatch (.mclk_in(mclk_in), .rst_in(rst_in), .ssp_enable_in(enable),
		.ssp_stop_in(stop), .rx_dword_in(rx_dword), .rx_eof_info_in(eof_info), .buf_free_in(buf_free),
		.credit_rcvd_out(evt[CR]), .ack_rcvd_out(evt[AK]), .nak_rcvd_out(evt[NK]), .done_rcvd_out(evt[DN]),
		.done_reason_out(done_reason), .eof_rcvd_out(evt[EF]), .remote_ack_to_out(evt[RAT]),
		.remote_credit_to_out(evt[RCT]), .illegal_frame_out(evt[IL]), .protocol_violation_out(evt[PV]),
		.frame_rcvd_out(evt[FR]), .frame_balanced_out(fr_bal), .frame_failed_out(evt[FF]),
		.credit_extended_out(cred_ext), .ack_balanced_out(ack_bal), .stopped_out(stopped),
		.rx_data_out(rx_data), .rx_valid_out(rx_valid), .rx_ready_in(rx_ready), .tx_done_req_in(done_req),
		.tx_done_reason_in(done_rsn), .tx_done_ack_out(done_ack), .tx_frame_data_in(f_data),
		.tx_frame_valid_in(f_valid), .tx_frame_last_in(f_last), .tx_frame_ready_out(f_ready),
		.tx_dword_out(tx_dword));
	sslrx_peer i_sslrx_peer (.mclk_in(mclk_in), .tx_dword_in(tx_dword), .rx_dword_out(rx_dword),
		.rx_eof_info_out(eof_info));
	// ----------------------------------------
	// clock, monitor and shared tasks
	// ----------------------------------------
	always #5 mclk_in = ~mclk_in;
	always @(posedge mclk_in) begin
		if (rst_in === 1'b0) begin
			for (int i = 0; i < 11; i++) begin
				ev[i] += (evt[i] === 1'b1);
			end
			txk[tx_dword.kind] += 1;
			if (tx_dword.kind > sslrx_pkg::SSLRX_K_ALIGN) begin
				seq.push_back(tx_dword);
			end
		end
	end
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge mclk_in);
	endtask
	task automatic give_verdict();
		if (miscompares == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_credit();
		chk("idle kind", sslrx_pkg::SSLRX_K_IDLE, tx_dword.kind);
		chk("stopped", 1'b1, stopped);
		enable = 1'b1;
		cyc(20);
		chk("credit ext", 1'b0, cred_ext);
		chk("rrdy sent", 0, txk[sslrx_pkg::SSLRX_K_RRDY]);
		repeat (3) begin
			buf_free = 1'b1;
			cyc(1);
			buf_free = 1'b0;
			cyc(1);
		end
		cyc(10);
		chk("rrdy sent", 3, txk[sslrx_pkg::SSLRX_K_RRDY]);
		chk("credit ext", 1'b1, cred_ext);
	endtask
	task automatic t_prims();
		i_sslrx_peer.put(sslrx_pkg::SSLRX_K_RRDY, 2'h0, 32'h0, 2'h0);
		i_sslrx_peer.put(sslrx_pkg::SSLRX_K_ACK, 2'h0, 32'h0, 2'h0);
		i_sslrx_peer.put(sslrx_pkg::SSLRX_K_NAK, 2'h0, 32'h0, 2'h0);
		i_sslrx_peer.idle();
		cyc(4);
		chk("credit rcvd", 1, ev[CR]);
		chk("ack rcvd", 1, ev[AK]);
		chk("nak rcvd", 1, ev[NK]);
	endtask
	task automatic t_rx_frames();
		int g;
		rx_ready = 1'b0;
		i_sslrx_peer.frame(4, 2'h3, 1'b0);
		cyc(8);
		chk("frame rcvd", 1, ev[FR]);
		chk("eof rcvd", 1, ev[EF]);
		chk("ack sent", 1, txk[sslrx_pkg::SSLRX_K_ACK]);
		chk("frame bal", 1'b0, fr_bal);
		for (int i = 0; i < 4; i++) begin
			g = 0;
			while (rx_valid !== 1'b1 && g < 20) begin
				cyc(1);
				g++;
			end
			chk("rx data", 32'h00001000 + i, rx_data);
			rx_ready = 1'b1;
			cyc(1);
			rx_ready = 1'b0;
		end
		rx_ready = 1'b1;
		i_sslrx_peer.frame(2, 2'h1, 1'b0);
		cyc(8);
		chk("frame failed", 1, ev[FF]);
		chk("nak sent", 1, txk[sslrx_pkg::SSLRX_K_NAK]);
		i_sslrx_peer.frame(2, 2'h2, 1'b1);
		cyc(8);
		chk("illegal addr", 1, ev[IL]);
		i_sslrx_peer.frame(257, 2'h3, 1'b1);
		cyc(8);
		chk("illegal long", 2, ev[IL]);
		i_sslrx_peer.frame(1, 2'h3, 1'b0);
		cyc(8);
		chk("frame rcvd", 2, ev[FR]);
		chk("frame bal", 1'b1, fr_bal);
		chk("credit ext", 1'b0, cred_ext);
		chk("ack bal", 1'b0, ack_bal);
		i_sslrx_peer.frame(1, 2'h3, 1'b1);
		cyc(8);
		chk("illegal credit", 3, ev[IL]);
		i_sslrx_peer.put(sslrx_pkg::SSLRX_K_ACK, 2'h0, 32'h0, 2'h0);
		i_sslrx_peer.idle();
		cyc(4);
		chk("ack bal", 1'b1, ack_bal);
		for (int i = 0; i < 5; i++) begin
			i_sslrx_peer.put(sslrx_pkg::sslrx_kind_e'(i == 4 ? 8 : 6 + i % 2),
				2'h0, 32'h0, 2'h3);
		end
		i_sslrx_peer.idle();
		cyc(8);
		chk("violation", 1, ev[PV]);
	endtask
	task automatic t_tx();
		int i = 0;
		int g = 0;
		sslrx_pkg::sslrx_dword_s f[$];
		sslrx_pkg::sslrx_kind_e ek[4] = '{sslrx_pkg::SSLRX_K_SOF, sslrx_pkg::SSLRX_K_DATA,
			sslrx_pkg::SSLRX_K_DATA, sslrx_pkg::SSLRX_K_EOF};
		seq.delete();
		while (i < 2 && g < 50) begin
			f_valid = 1'b1;
			f_data = 32'h0000a5a5 + i;
			f_last = (i == 1);
			#1;
			i += (f_ready === 1'b1);
			g++;
			cyc(1);
		end
		f_valid = 1'b0;
		cyc(6);
		f = seq.find(x) with (x.kind inside {sslrx_pkg::SSLRX_K_SOF, sslrx_pkg::SSLRX_K_DATA, sslrx_pkg::SSLRX_K_EOF});
		chk("frame dwords", 4, f.size());
		for (int k = 0; k < 4; k++) begin
			chk("frame kind", ek[k], f[k].kind);
		end
		chk("frame data", 32'h0000a5a6, f[2].data);
		seq.delete();
		buf_free = 1'b1;
		cyc(1);
		buf_free = 1'b0;
		done_req = 1'b1;
		done_rsn = 2'h1;
		g = 0;
		i = 0;
		while (i == 0 && g < 50) begin
			#1;
			i = (done_ack === 1'b1);
			cyc(1);
			g++;
		end
		done_req = 1'b0;
		cyc(4);
		chk("done ack", 1, i);
		chk("first rrdy", sslrx_pkg::SSLRX_K_RRDY, seq[0].kind);
		chk("then done", sslrx_pkg::SSLRX_K_DONE, seq[1].kind);
		chk("done reason", 2'h1, seq[1].reason);
	endtask
	task automatic t_done_stop();
		int b = ev[IL];
		i_sslrx_peer.put(sslrx_pkg::SSLRX_K_DONE, 2'h2, 32'h0, 2'h0);
		i_sslrx_peer.put(sslrx_pkg::SSLRX_K_DONE, 2'h1, 32'h0, 2'h0);
		i_sslrx_peer.idle();
		cyc(4);
		chk("done rcvd", 2, ev[DN]);
		chk("done reason", 2'h1, done_reason);
		chk("ack timeout", 1, ev[RAT]);
		chk("credit timeout", 1, ev[RCT]);
		i_sslrx_peer.frame(1, 2'h3, 1'b1);
		cyc(8);
		chk("illegal done", b + 1, ev[IL]);
		b = txk[sslrx_pkg::SSLRX_K_ALIGN];
		cyc(512);
		chk("aligns", 2, txk[sslrx_pkg::SSLRX_K_ALIGN] - b);
		enable = 1'b0;
		stop = 1'b1;
		cyc(1);
		stop = 1'b0;
		cyc(2);
		chk("stopped", 1'b1, stopped);
		i_sslrx_peer.put(sslrx_pkg::SSLRX_K_RRDY, 2'h0, 32'h0, 2'h0);
		i_sslrx_peer.idle();
		cyc(4);
		chk("credit rcvd", 1, ev[CR]);
		enable = 1'b1;
		cyc(2);
		chk("restart", 1'b0, stopped);
		enable = 1'b0;
		i_sslrx_peer.put(sslrx_pkg::SSLRX_K_BREAK, 2'h0, 32'h0, 2'h0);
		i_sslrx_peer.idle();
		chk("break", 1'b1, stopped);
	endtask
	initial begin
		cyc(2);
		rst_in = 1'b0;
		cyc(1);
		t_credit();
		t_prims();
		t_rx_frames();
		t_tx();
		t_done_stop();
		give_verdict();
	end
	// the whole sequence needs about 1000 cycles
	initial begin
		repeat (20000) @(posedge mclk_in);
		miscompares++;
		give_verdict();
	end
endmodule
